// *** src/lin_sync_consts.vh ***
`ifndef LIN_SYNC_CONSTS_VH
`define LIN_SYNC_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_DIV_HIGH     16'ha093
`define IDX_DIV_LOW      16'ha094
`define IDX_FLAGS        16'ha095
`define IDX_ENABLES      16'ha096
`define IDX_CONTROL      16'ha097

// Event flag and status bit positions
`define FLG_CNT_OVF      0
`define FLG_RX_SYNC      1
`define FLG_BRK_DONE     2
`define FLG_AUTO_SYNC    3
`define FLG_BUS_IDLE     4
`define FLG_BUS_LEVEL    5

// Enable register: master enable bit, event enables share flag positions
`define EN_MASTER        7

// Control register bit positions
`define CTL_LIN_EN       0
`define CTL_MASTER_MODE  1
`define CTL_AUTO_SYNC    2

// Reset values
`define RST_DIVISOR      16'h0000
`define RST_FLAGS        4'h0
`define RST_ENABLES      8'h00
`define RST_CONTROL      3'h0

// Timing counts, in bit times and cycles
`define BREAK_BITS       4'hb
`define SYNC_EDGES       3'h5
`define SYNC_BITS_SHIFT  3
`define CNT_ALL_ONES     16'hffff

`endif

// *** src/lin_baud_counter.v ***
`timescale 1ns/1ns
`default_nettype none
`include "lin_sync_consts.vh"

// Baud tick generator and the 16-bit LIN bit-time counter
module lin_baud_counter #(
   parameter W = 16
) (
   input  wire         clk_sys,
   input  wire         sys_rst,
   input  wire [W-1:0] divisor,    // Current bit-rate divisor
   input  wire         count_run,  // Counter advances only while LIN is on
   input  wire         count_clr,  // Restart the counter from zero
   output reg          baud_tick,  // One cycle per bit time
   output reg          overflow    // One cycle when counter hits all ones
);

   reg [W-1:0] div_cnt_r;          // Cycles within the current bit
   reg [W-1:0] lin_cnt_r;          // Bit times since last clear

   // Divide the system clock; a zero divisor is illegal, so it stalls
   // the generator rather than ticking every cycle
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         div_cnt_r <= {W{1'b0}};
         baud_tick <= 1'b0;
      end else if (divisor == {W{1'b0}}) begin
         div_cnt_r <= {W{1'b0}};
         baud_tick <= 1'b0;
      end else if (div_cnt_r >= divisor - {{(W-1){1'b0}}, 1'b1}) begin
         div_cnt_r <= {W{1'b0}};
         baud_tick <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + {{(W-1){1'b0}}, 1'b1};
         baud_tick <= 1'b0;
      end
   end

   // Counter saturates at all ones so overflow fires only once per run
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         lin_cnt_r <= {W{1'b0}};
         overflow  <= 1'b0;
      end else if (count_clr || !count_run) begin
         lin_cnt_r <= {W{1'b0}};
         overflow  <= 1'b0;
      end else if (baud_tick && lin_cnt_r != `CNT_ALL_ONES) begin
         lin_cnt_r <= lin_cnt_r + {{(W-1){1'b0}}, 1'b1};
         overflow  <= (lin_cnt_r == (`CNT_ALL_ONES - 16'h0001));
      end else begin
         overflow  <= 1'b0;
      end
   end

endmodule // lin_baud_counter
`default_nettype wire

// *** src/lin_sync_measure.v ***
`timescale 1ns/1ns
`default_nettype none
`include "lin_sync_consts.vh"

// Break detector and sync field timer for slave operation
module lin_sync_measure (
   input  wire        clk_sys,
   input  wire        sys_rst,
   input  wire        enable,      // Slave mode with LIN on
   input  wire        rx,          // Synchronised receive line
   input  wire        bit_tick,    // One cycle per bit time
   output reg         busy,        // Break or sync in progress
   output reg         sync_valid,  // One cycle pulse, result good
   output reg  [15:0] measured     // Cycles per bit from the sync field
);

   localparam S_IDLE  = 2'd0;
   localparam S_BREAK = 2'd1;
   localparam S_START = 2'd2;
   localparam S_MEAS  = 2'd3;

   reg [1:0]  state_r;             // Sequence state
   reg        rx_prev_r;           // Line one cycle ago
   reg [3:0]  low_bits_r;          // Dominant bit times in break
   reg [19:0] span_r;              // Cycles since the first sync edge
   reg [19:0] mark_r;              // Span at the previous falling edge
   reg [19:0] first_r;             // First two-bit interval
   reg [2:0]  edges_r;             // Falling edges seen in sync field
   reg        ok_r;                // All intervals within tolerance

   wire        fall     = rx_prev_r & ~rx;
   wire [19:0] elapsed  = span_r + 20'd1;
   wire [19:0] interval = elapsed - mark_r;
   wire [19:0] diff     = (interval > first_r) ? interval - first_r : first_r - interval;
   // Interval counts as matching if within one eighth of the first one
   wire        in_tol   = (diff <= (first_r >> 3));
   wire [19:0] rounded  = elapsed + 20'd4;

   // Sync byte 0x55 gives five falling edges spanning eight bit times
   always @(posedge clk_sys) begin
      if (sys_rst || !enable) begin
         state_r <= S_IDLE;
         rx_prev_r <= 1'b1;
         low_bits_r <= 4'h0;
         span_r <= 20'h00000;
         mark_r <= 20'h00000;
         first_r <= 20'h00000;
         edges_r <= 3'h0;
         ok_r <= 1'b0;
         busy <= 1'b0;
         sync_valid <= 1'b0;
         measured <= 16'h0000;
      end else begin
         rx_prev_r <= rx;
         sync_valid <= 1'b0;
         case (state_r)
            S_IDLE: begin
               busy <= 1'b0;
               if (!rx) begin
                  state_r <= S_BREAK;
                  low_bits_r <= 4'h0;
                  busy <= 1'b1;
               end
            end
            S_BREAK: begin
               // Short dominant phases are ordinary data, not a break
               if (rx) begin
                  state_r <= (low_bits_r >= `BREAK_BITS) ? S_START : S_IDLE;
               end else if (bit_tick && low_bits_r != `BREAK_BITS) begin
                  low_bits_r <= low_bits_r + 4'h1;
               end
            end
            S_START: begin
               if (fall) begin
                  state_r <= S_MEAS;
                  span_r <= 20'h00000;
                  mark_r <= 20'h00000;
                  edges_r <= 3'h1;
                  ok_r <= 1'b1;
               end
            end
            S_MEAS: begin
               span_r <= elapsed;
               if (span_r == 20'hfffff) begin
                  state_r <= S_IDLE;
               end else if (fall) begin
                  mark_r <= elapsed;
                  edges_r <= edges_r + 3'h1;
                  if (edges_r == 3'h1) begin
                     first_r <= interval;
                  end else if (!in_tol) begin
                     ok_r <= 1'b0;
                  end
                  if (edges_r == `SYNC_EDGES - 3'h1) begin
                     state_r <= S_IDLE;
                     measured <= rounded[18:3];
                     sync_valid <= ok_r && in_tol && (rounded[18:3] != 16'h0000);
                  end
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule // lin_sync_measure
`default_nettype wire

// *** src/lin_baud_sync_irq.v ***
// Behaviour
// - Bit rate is clock over written divisor
// - Read-only capture of last measured divisor
// - Valid sync after break captures, sets flag
// - Capture is clock cycles per master bit
// - Auto update loads divisor, sets both flags
// - Bit 5 shows receive line level
// - Bit 4 idle; forced when LIN off
// - Auto-sync flag bit 3, write-one clears
// - Counter all ones sets overflow flag
// - Master enable bit 7 gates interrupt
// - Separate enables at bits 3, 2, 1, 0
// - Master mode select; sync only in slave
//
// Decided for this implementation: the APB register port.

`timescale 1ns/1ns
`default_nettype none
`include "lin_sync_consts.vh"

module lin_baud_sync_irq (
   input  wire        clk_sys,
   input  wire        sys_rst,
   // APB slave
   // Byte registers use bits 7..0
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [17:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // LIN line and serial datapath hooks
   // Pin is async, the rest same clock
   input  wire        lin_rx,          // Receive pin, asynchronous
   input  wire        tx_busy,         // Datapath is sending a byte
   input  wire        rx_busy,         // Datapath is receiving a byte
   input  wire        send_break_start,// Pulse: break transmission begins
   input  wire        send_break_done, // Pulse: break transmission ended
   // To the serial datapath and the interrupt controller
   // All outputs leave from flops
   output wire        baud_tick,
   output reg  [15:0] baud_divisor,
   output reg         lin_irq
);

   // One byte register per bus word.
   // Unmapped words answer with error.
   // Shared by writes, reads and errors.
   // Decode a register index into its word address on the bus
   function hit;
      input [17:0] addr;
      input [15:0] idx;
      begin
         hit = (addr == {idx, 2'b00});
      end
   endfunction

   // Receive line synchroniser; idles recessive so no false break at reset
   // Two flops delay each line edge.
   // rx_prev_r only spots transitions.
   reg         rx_meta_r;          // First stage, read only by rx_sync_r
   reg         rx_sync_r;          // Safe receive level
   reg         rx_prev_r;          // For transition detection

   // Software visible state
   // Idle and level bits are not held
   // here; the read mux builds them.
   reg  [3:0]  flags_r;            // Sticky event flags, bits 3..0
   reg  [7:0]  enables_r;          // Master and event enables
   reg  [2:0]  control_r;          // LIN on, master mode, auto sync
   reg  [15:0] captured_divisor_r; // Last good sync measurement
   reg         bus_idle_r;         // Registered idle status

   // Bus phases
   // Writes act only at the edge where
   // ready is seen in the access phase.
   // Ready comes from one flop stage.
   wire        access   = psel & penable;
   wire        done     = access & pready;
   wire        wr_done  = done & pwrite;
   wire        mapped   = hit(paddr, `IDX_DIV_HIGH) | hit(paddr, `IDX_DIV_LOW) |
                          hit(paddr, `IDX_FLAGS)    | hit(paddr, `IDX_ENABLES) |
                          hit(paddr, `IDX_CONTROL);

   // Mode decode
   // Control word is a local addition.
   // Capture needs slave role, LIN on.
   wire        lin_operation_enable    = control_r[`CTL_LIN_EN];
   wire        master_mode_select      = control_r[`CTL_MASTER_MODE];
   wire        auto_sync_update_enable = control_r[`CTL_AUTO_SYNC];
   wire        slave_active = lin_operation_enable & ~master_mode_select;

   // Outputs of the helpers
   // Overflow and sync_valid pulse once.
   wire        counter_ovf;
   wire        meas_busy;
   wire        sync_valid;
   wire [15:0] sync_measured;

   // Counter restarts on break start (master) or any line edge (slave)
   // Master: frame time base. Slave:
   // time the bus has stayed quiet.
   wire        rx_edge   = rx_sync_r ^ rx_prev_r;
   wire        cnt_clear = master_mode_select ? send_break_start : rx_edge;

   // Flag set and clear terms
   // Recomputed every cycle.
   reg  [3:0]  flag_set;
   reg  [3:0]  flag_clr;
   reg  [3:0]  flags_nxt;
   reg  [31:0] rdata_nxt;

   // Baud tick and LIN counter
   lin_baud_counter #(
      .W (16)
   ) u_counter (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .divisor   (baud_divisor),
      .count_run (lin_operation_enable),
      .count_clr (cnt_clear),
      .baud_tick (baud_tick),
      .overflow  (counter_ovf)
   );

   // Break and sync timer, slave only
   lin_sync_measure u_measure (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .enable     (slave_active),
      .rx         (rx_sync_r),
      .bit_tick   (baud_tick),
      .busy       (meas_busy),
      .sync_valid (sync_valid),
      .measured   (sync_measured)
   );

   // Two-stage synchroniser for the pin
   // Reset loads the recessive level so
   // leaving reset is not a false break.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_meta_r <= lin_rx;
         rx_sync_r <= rx_meta_r;
         rx_prev_r <= rx_sync_r;
      end
   end

   // Event sources and software clears for the sticky flags
   // Set beats clear in one cycle, so an
   // event during an acknowledge stays.
   always @* begin
      flag_set = 4'h0;
      flag_set[`FLG_CNT_OVF]   = counter_ovf;
      flag_set[`FLG_RX_SYNC]   = sync_valid & slave_active;
      flag_set[`FLG_BRK_DONE]  = send_break_done & lin_operation_enable;
      flag_set[`FLG_AUTO_SYNC] = sync_valid & slave_active &
                                 auto_sync_update_enable;
      flag_clr = 4'h0;
      if (wr_done && hit(paddr, `IDX_FLAGS)) begin
         // Writing zero leaves a flag alone; status bits are not writable
         flag_clr = pwdata[3:0];
      end
      // A new event in the clearing cycle survives the clear
      flags_nxt = (flags_r & ~flag_clr) | flag_set;
   end

   // Sticky flags
   // Reset clears every flag.
   // Only bits 3..0 are stored.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         flags_r <= `RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Divisor: written by software, or loaded by hardware after a sync.
   // Hardware load wins a same-cycle clash so the node stays locked.
   // Each byte lands on its own write,
   // so a two-byte change passes one
   // mixed rate in between. Zero is
   // illegal and stalls the ticks.
   // The capture reads back here.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         baud_divisor <= `RST_DIVISOR;
      end else if (sync_valid && slave_active && auto_sync_update_enable) begin
         baud_divisor <= sync_measured;
      end else if (wr_done && hit(paddr, `IDX_DIV_HIGH)) begin
         baud_divisor[15:8] <= pwdata[7:0];
      end else if (wr_done && hit(paddr, `IDX_DIV_LOW)) begin
         baud_divisor[7:0] <= pwdata[7:0];
      end
   end

   // Capture of the measured divisor, kept until the next good sync
   // Only a sync that passed every
   // interval check reaches this point.
   // Mode changes leave it in place.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         captured_divisor_r <= 16'h0000;
      end else if (sync_valid && slave_active) begin
         captured_divisor_r <= sync_measured;
      end
   end

   // Enables and control
   // A role change mid frame drops any
   // break or sync being measured.
   // Pending flags raise the request as
   // soon as their enable is set.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         enables_r <= `RST_ENABLES;
         control_r <= `RST_CONTROL;
      end else begin
         if (wr_done && hit(paddr, `IDX_ENABLES)) begin
            // Bits 6..4 are not implemented and stay zero
            enables_r <= {pwdata[7], 3'b000, pwdata[3:0]};
         end
         if (wr_done && hit(paddr, `IDX_CONTROL)) begin
            control_r <= pwdata[2:0];
         end
      end
   end

   // Idle while nothing is moving on the line, and always when LIN is off
   // Registered so reads see it settled.
   // Measure busy covers break and sync.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         bus_idle_r <= 1'b1;
      end else begin
         bus_idle_r <= ~lin_operation_enable |
                       (~tx_busy & ~rx_busy & ~meas_busy);
      end
   end

   // Level interrupt from enabled flags under the master enable
   // One cycle behind the flags; a
   // clear drops it a cycle later.
   // Master enable overrides the rest.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         lin_irq <= 1'b0;
      end else begin
         lin_irq <= enables_r[`EN_MASTER] & (|(flags_r & enables_r[3:0]));
      end
   end

   // Read multiplexer; divisor reads return the capture, not the divisor
   // Unmapped words read as zero.
   // Status bits are live, not stored.
   // The divisor never reads back.
   always @* begin
      rdata_nxt = 32'h00000000;
      if (hit(paddr, `IDX_DIV_HIGH)) begin
         rdata_nxt[7:0] = captured_divisor_r[15:8];
      end else if (hit(paddr, `IDX_DIV_LOW)) begin
         rdata_nxt[7:0] = captured_divisor_r[7:0];
      end else if (hit(paddr, `IDX_FLAGS)) begin
         rdata_nxt[3:0] = flags_r;
         rdata_nxt[`FLG_BUS_IDLE]  = bus_idle_r;
         rdata_nxt[`FLG_BUS_LEVEL] = rx_sync_r;
      end else if (hit(paddr, `IDX_ENABLES)) begin
         rdata_nxt[7:0] = enables_r;
      end else if (hit(paddr, `IDX_CONTROL)) begin
         rdata_nxt[2:0] = control_r;
      end
   end

   // One wait state: ready rises in the second access cycle. Data and
   // error are registered with it so all three outputs come from flops.
   // A master that waits for ready works
   // whatever the latency turns out.
   // Write responses carry zero data.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (access && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

endmodule // lin_baud_sync_irq
`default_nettype wire

// *** tb/lin_sync_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lin_sync_consts.vh"
module lin_sync_checker (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        baud_tick,
   input wire logic [15:0] baud_divisor,
   input wire logic        lin_irq
);
   localparam [17:0] A_LOW = {`IDX_DIV_LOW, 2'b00};
   localparam [17:0] A_EN  = {`IDX_ENABLES, 2'b00};
   wire        acc;     // Transfer completes at this edge
   logic [7:0]  en_r;   // Shadow of the enable register
   logic [15:0] gap_r;  // Cycles since the last tick
   logic        stab_r; // Divisor unchanged since the last tick
   assign acc = psel & penable & pready;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Shadow state; a divisor change voids the next spacing check
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         en_r   <= 8'h00;
         gap_r  <= 16'h0000;
         stab_r <= 1'b0;
      end else begin
         if (acc && pwrite && paddr == A_EN)
            en_r <= pwdata[7:0];
         gap_r <= baud_tick ? 16'h0001 : gap_r + 16'h0001;
         if (baud_divisor != $past(baud_divisor))
            stab_r <= 1'b0;
         else if (baud_tick)
            stab_r <= 1'b1;
      end
   end
   property p_ready_wait;
      $rose(penable) && psel |-> !pready ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
   property p_err_empty;
      pslverr |-> pready && prdata == 32'h0000_0000;
   endproperty
   a_err_empty: assert property (p_err_empty) else $error("error response carries data");
   property p_idle_rdata;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside response");
   property p_upper_zero;
      pready |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
   property p_div_low;
      acc && pwrite && paddr == A_LOW |=> baud_divisor[7:0] == $past(pwdata[7:0]);
   endproperty
   a_div_low: assert property (p_div_low) else $error("divisor low byte not loaded");
   property p_tick_space;
      baud_tick && stab_r |-> gap_r == baud_divisor;
   endproperty
   a_tick_space: assert property (p_tick_space) else $error("tick spacing differs");
   property p_gate;
      !en_r[7] && !$past(en_r[7]) |-> !lin_irq;
   endproperty
   a_gate: assert property (p_gate) else $error("interrupt with master enable clear");
   property p_rise;
      $rose(lin_irq) |-> $past(en_r[7]);
   endproperty
   a_rise: assert property (p_rise) else $error("interrupt rose while disabled");
   property p_en_read;
      acc && !pwrite && paddr == A_EN |-> prdata[7:0] == (en_r & 8'h8f);
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable readback wrong");
   c_err: cover property (acc && pslverr);
   c_irq: cover property ($rose(lin_irq));
   c_tick: cover property (baud_tick && stab_r);
endmodule // lin_sync_checker
bind lin_baud_sync_irq lin_sync_checker chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
   .baud_divisor(baud_divisor), .lin_irq(lin_irq)
);
`default_nettype wire

// *** tb/lin_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Far-end node driving the receive line; pulled up, so idle is recessive
module lin_master_model (
   input  wire logic clk_sys,
   output var  logic lin_rx
);
   initial lin_rx = 1'b1;
   // Hold one level for n cycles, changed right after an edge
   task automatic hold(input logic v, input int n);
      lin_rx <= v;
      repeat (n) @(posedge clk_sys);
   endtask
   // Break, delimiter, then sync byte 0x55 LSB first with start and stop
   task automatic send_header(input int per);
      @(posedge clk_sys);
      hold(1'b0, 13 * per);
      hold(1'b1, per);
      hold(1'b0, per);
      for (int i = 0; i < 8; i++)
         hold(i[0] == 1'b0, per);
      hold(1'b1, per);
   endtask
   // Static level for status reads
   task automatic set_level(input logic v);
      @(posedge clk_sys);
      lin_rx <= v;
   endtask
endmodule // lin_master_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lin_sync_consts.vh"
module tb_top;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h0;
   logic        tx_busy = 1'b0;
   logic        rx_busy = 1'b0;
   logic        brk_go = 1'b0;   // Break start pulse
   logic        brk_end = 1'b0;  // Break done pulse
   logic [31:0] prdata;
   logic        pready, pslverr, lin_rx, baud_tick, lin_irq;
   logic [15:0] baud_divisor;
   logic [7:0]  rd;             // Last read byte
   logic        er;             // Last error response
   int          err_count = 0;
   int          comparisons = 0;

   initial forever #25 clk_sys = ~clk_sys;

   lin_baud_sync_irq dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lin_rx(lin_rx), .tx_busy(tx_busy),
      .rx_busy(rx_busy), .send_break_start(brk_go), .send_break_done(brk_end),
      .baud_tick(baud_tick), .baud_divisor(baud_divisor), .lin_irq(lin_irq)
   );
   lin_master_model far (.clk_sys(clk_sys), .lin_rx(lin_rx));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; waits for pready without assuming a latency
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rdc(input string what, input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(what, {8'h00, exp}, {8'h00, rd});
   endtask
   task automatic irqc(input logic exp);
      repeat (3) @(posedge clk_sys);
      chk("lin_irq", {15'h0000, exp}, {15'h0000, lin_irq});
   endtask

   // Reset values, status bits, unmapped access
   task automatic t_reset;
      rdc("flags", `IDX_FLAGS, 8'h30);
      rdc("enables", `IDX_ENABLES, 8'h00);
      rdc("captured high", `IDX_DIV_HIGH, 8'h00);
      rdc("captured low", `IDX_DIV_LOW, 8'h00);
      apb(1'b0, 16'h0123, 8'h00);
      chk("unmapped error", 16'h0001, {15'h0000, er});
   endtask
   // Written divisor sets tick rate
   task automatic t_divisor;
      int n;
      n = 0;
      wr(`IDX_DIV_HIGH, 8'h00);
      wr(`IDX_DIV_LOW, 8'h10);
      repeat (2) @(posedge clk_sys);
      chk("divisor", 16'h0010, baud_divisor);
      repeat (160) begin
         @(posedge clk_sys);
         n += baud_tick;
      end
      chk("ticks", 16'h000a, n[15:0]);
   endtask
   // Slave capture without auto update, interrupt gating
   task automatic t_slave;
      wr(`IDX_CONTROL, 8'h01);
      far.send_header(20);
      repeat (10) @(posedge clk_sys);
      rdc("flags", `IDX_FLAGS, 8'h32);
      rdc("captured high", `IDX_DIV_HIGH, 8'h00);
      rdc("captured low", `IDX_DIV_LOW, 8'h14);
      chk("divisor", 16'h0010, baud_divisor);
      wr(`IDX_ENABLES, 8'h02);
      irqc(1'b0);
      wr(`IDX_ENABLES, 8'h82);
      irqc(1'b1);
      wr(`IDX_FLAGS, 8'h02);
      irqc(1'b0);
   endtask
   // Auto update loads the divisor and sets both flags
   task automatic t_auto;
      wr(`IDX_CONTROL, 8'h05);
      far.send_header(24);
      repeat (10) @(posedge clk_sys);
      rdc("flags", `IDX_FLAGS, 8'h3a);
      chk("divisor", 16'h0018, baud_divisor);
      rdc("captured low", `IDX_DIV_LOW, 8'h18);
      wr(`IDX_FLAGS, 8'h00);
      rdc("flags", `IDX_FLAGS, 8'h3a);
      wr(`IDX_FLAGS, 8'h08);
      rdc("flags", `IDX_FLAGS, 8'h32);
      wr(`IDX_FLAGS, 8'h02);
   endtask
   // Master mode: no capture; break done, line level, idle
   task automatic t_master;
      wr(`IDX_CONTROL, 8'h03);
      far.send_header(20);
      repeat (10) @(posedge clk_sys);
      rdc("flags", `IDX_FLAGS, 8'h30);
      rdc("captured low", `IDX_DIV_LOW, 8'h18);
      @(posedge clk_sys) brk_end <= 1'b1;
      @(posedge clk_sys) brk_end <= 1'b0;
      rdc("flags", `IDX_FLAGS, 8'h34);
      wr(`IDX_ENABLES, 8'h84);
      irqc(1'b1);
      wr(`IDX_ENABLES, 8'h04);
      irqc(1'b0);
      wr(`IDX_FLAGS, 8'h04);
      far.set_level(1'b0);
      rdc("flags", `IDX_FLAGS, 8'h10);
      far.set_level(1'b1);
      tx_busy <= 1'b1;
      rdc("flags", `IDX_FLAGS, 8'h20);
      tx_busy <= 1'b0;
      rx_busy <= 1'b1;
      rdc("flags", `IDX_FLAGS, 8'h20);
      rx_busy <= 1'b0;
   endtask
   // Counter overflow sets the flag after a full run of ticks at divisor 1
   task automatic t_overflow;
      int n;
      n = 0;
      wr(`IDX_DIV_LOW, 8'h01);
      @(posedge clk_sys) brk_go <= 1'b1;
      @(posedge clk_sys) brk_go <= 1'b0;
      wr(`IDX_FLAGS, 8'h0f);
      wr(`IDX_ENABLES, 8'h81);
      while (lin_irq !== 1'b1 && n < 70000) begin
         @(posedge clk_sys);
         n++;
      end
      chk("overflow late", 16'h0001, {15'h0000, n > 65000 && n < 66000});
      rdc("flags", `IDX_FLAGS, 8'h31);
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset;
      t_divisor;
      t_slave;
      t_auto;
      t_master;
      t_overflow;
      close_out;
   end
   // Watchdog, well past the longest expected run
   initial begin
      repeat (90000) @(posedge clk_sys);
      err_count++;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
